// ===== irsfc_defines.vh
// register map, field positions, reset values and timing counts of the serial frame block
`ifndef IRSFC_DEFINES_VH
`define IRSFC_DEFINES_VH
`define IRSFC_ADDR_CTRL1    3'h0
`define IRSFC_ADDR_CTRL2    3'h1
`define IRSFC_ADDR_STAT1    3'h2
`define IRSFC_ADDR_DATA     3'h3
`define IRSFC_ADDR_BAUD     3'h4
`define IRSFC_ADDR_IRCR     3'h5
`define IRSFC_ADDR_PDIR     3'h6
`define IRSFC_ADDR_PDATA    3'h7
`define IRSFC_C1_LOOP       7
`define IRSFC_C1_UNIT       6
`define IRSFC_C1_CHAR9      4
`define IRSFC_C1_WAKE       3
`define IRSFC_C1_IDLE_ORG   2
`define IRSFC_C1_PAR_ON     1
`define IRSFC_C1_PAR_ODD    0
`define IRSFC_C1_MASK       8'hdf
`define IRSFC_C2_SCTIE      7
`define IRSFC_C2_TCIE       6
`define IRSFC_C2_SCRIE      5
`define IRSFC_C2_ILIE       4
`define IRSFC_C2_TE         3
`define IRSFC_C2_RE         2
`define IRSFC_C2_RWU        1
`define IRSFC_C2_MASK       8'hfe
`define IRSFC_S1_TX_BUFFER_EMPTY_FLAG       7
`define IRSFC_S1_TC         6
`define IRSFC_S1_RX_FULL_FLAG       5
`define IRSFC_S1_IDLE       4
`define IRSFC_S1_OVR        3
`define IRSFC_S1_FE         1
`define IRSFC_S1_PE         0
`define IRSFC_IR_EN         0
`define IRSFC_IR_T8         6
`define IRSFC_IR_R8         7
`define IRSFC_RST_CTRL1     8'h00
`define IRSFC_RST_CTRL2     8'h00
`define IRSFC_RST_BAUD      8'h00
`define IRSFC_RT_LAST       4'hf
`define IRSFC_RT_MID        4'h7
`define IRSFC_IR_PULSE_END  4'h2
`define IRSFC_BITS_CHAR8    4'ha
`define IRSFC_BITS_CHAR9    4'hb
`endif

// ===== irsfc_ir_enc.v
// infrared encoder: a zero bit becomes a short low pulse at the start of the bit
`timescale 1ns/1ns
`default_nettype none
`include "irsfc_defines.vh"
module irsfc_ir_enc
(
    input  wire       clk_in,
    input  wire       reset_n_in,
    input  wire       ir_on_in,
    input  wire       bit_in,
    input  wire [3:0] rt_phase_in,
    output reg        enc_out
);
    reg next_enc;

    always @*
    begin
        next_enc = bit_in;
        if (ir_on_in)
        begin
            next_enc = bit_in | (rt_phase_in > `IRSFC_IR_PULSE_END);
        end
    end

    always @(posedge clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            enc_out <= 1'b1;
        end
        else
        begin
            enc_out <= next_enc;
        end
    end
endmodule
`default_nettype wire

// ===== irsfc_top.v
// serial unit with infrared output path, shared port pins and frame format control
//
// Chosen here: the register offsets and strobed register access.
`timescale 1ns/1ns
`default_nettype none
`include "irsfc_defines.vh"
module irsfc_top
(
    input  wire       clk_in,
    input  wire       reset_n_in,
    input  wire [2:0] addr_in,
    input  wire [7:0] wdata_in,
    input  wire       wr_in,
    input  wire       rd_in,
    output reg  [7:0] rdata_out,
    output reg        tx_pin_out,
    output reg        tx_pin_oe_n_out,
    input  wire       tx_pin_in,
    output reg        rx_pin_out,
    output reg        rx_pin_oe_n_out,
    input  wire       rx_pin_in
);
    localparam RX_IDLE = 1'b0;
    localparam RX_BITS = 1'b1;

    function parity8;
        input [7:0] v;
        input       n8;
        input       odd;
        begin
            parity8 = ^(n8 ? v : {1'b0, v[6:0]}) ^ odd;
        end
    endfunction

    reg [7:0]  ctrl1;
    reg [7:0]  ctrl2;
    reg [7:0]  baud;
    reg        ir_on;
    reg        t8;
    reg        r8;
    reg [7:0]  port_dir;
    reg [7:0]  port_data;
    reg [7:0]  tx_hold;
    reg        tx_pend;
    reg        pre_pend;
    reg        tx_buffer_empty_flag;
    reg        tc;
    reg        rx_full_flag;
    reg        idle_flag;
    reg        ovr;
    reg        fe;
    reg        pe;
    reg [7:0]  rx_hold;
    reg [7:0]  div_cnt;
    reg        rt_tick;
    reg [10:0] tx_shift;
    reg [3:0]  tx_left;
    reg [3:0]  tx_rt;
    reg        tx_busy;
    reg [1:0]  rx_sync;
    reg [1:0]  txp_sync;
    reg        rx_state;
    reg [3:0]  rx_rt;
    reg [3:0]  rx_bitn;
    reg [8:0]  rx_shift;
    reg        rx_mid;
    reg        rx_low_seen;
    reg [3:0]  ones_cnt;
    reg [3:0]  idle_rt;
    reg        idle_armed;
    wire       ir_tx;

    wire unit   = ctrl1[`IRSFC_C1_UNIT];
    wire char9  = ctrl1[`IRSFC_C1_CHAR9];
    wire par_on = ctrl1[`IRSFC_C1_PAR_ON];
    wire odd    = ctrl1[`IRSFC_C1_PAR_ODD];
    wire te     = ctrl2[`IRSFC_C2_TE];
    wire re     = ctrl2[`IRSFC_C2_RE];
    wire standby_bit    = ctrl2[`IRSFC_C2_RWU];
    wire loop   = ctrl1[`IRSFC_C1_LOOP] & te & re;
    wire [3:0] frame_bits = char9 ? `IRSFC_BITS_CHAR9 : `IRSFC_BITS_CHAR8;
    wire tx_raw = tx_busy ? tx_shift[0] : 1'b1;
    wire rx_line = loop ? tx_raw : rx_sync[1];
    wire ir_dec  = ir_on & ~loop;
    wire wr_data = wr_in && addr_in == `IRSFC_ADDR_DATA;
    wire rd_data = rd_in && addr_in == `IRSFC_ADDR_DATA;
    wire tx_load = unit && !tx_busy && te && (pre_pend || tx_pend);
    wire rx_run  = unit & re;
    wire rx_bit  = ir_dec ? ~rx_low_seen : rx_mid;
    wire rx_done = rx_state == RX_BITS && rt_tick && rx_rt == `IRSFC_RT_LAST && rx_bitn == frame_bits - 4'h1;
    wire [7:0] rx_char = char9 ? rx_shift[7:0] : rx_shift[8:1];
    wire rx_top  = char9 ? rx_shift[8] : rx_shift[8];
    wire rx_pbad = parity8(char9 ? rx_shift[7:0] : rx_shift[8:1], char9, odd) != rx_top;
    wire idle_hit = idle_armed && ones_cnt >= frame_bits;

    // register writes
    always @(posedge clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            ctrl1     <= `IRSFC_RST_CTRL1;
            ctrl2     <= `IRSFC_RST_CTRL2;
            baud      <= `IRSFC_RST_BAUD;
            ir_on     <= 1'b0;
            t8        <= 1'b0;
            port_dir  <= 8'h00;
            port_data <= 8'h00;
            tx_hold   <= 8'h00;
        end
        else
        begin
            if (wr_in && addr_in == `IRSFC_ADDR_CTRL1)
            begin
                ctrl1 <= wdata_in & `IRSFC_C1_MASK;
            end
            if (wr_in && addr_in == `IRSFC_ADDR_CTRL2)
            begin
                ctrl2[7:4] <= wdata_in[7:4];
                ctrl2[`IRSFC_C2_RWU] <= wdata_in[`IRSFC_C2_RWU];
                // enables only writable with unit on
                if (unit)
                begin
                    ctrl2[`IRSFC_C2_TE] <= wdata_in[`IRSFC_C2_TE];
                    ctrl2[`IRSFC_C2_RE] <= wdata_in[`IRSFC_C2_RE];
                end
            end
            else if (standby_bit && ((rx_done && ctrl1[`IRSFC_C1_WAKE] && rx_top && rx_run) ||
                             (idle_hit && !ctrl1[`IRSFC_C1_WAKE])))
            begin
                ctrl2[`IRSFC_C2_RWU] <= 1'b0;
            end
            if (!unit)
            begin
                ctrl2[`IRSFC_C2_SCTIE] <= 1'b0;
                ctrl2[`IRSFC_C2_TCIE]  <= 1'b0;
            end
            if (wr_in && addr_in == `IRSFC_ADDR_BAUD)
            begin
                baud <= wdata_in;
            end
            if (wr_in && addr_in == `IRSFC_ADDR_IRCR)
            begin
                ir_on <= wdata_in[`IRSFC_IR_EN];
                t8    <= wdata_in[`IRSFC_IR_T8];
            end
            if (wr_in && addr_in == `IRSFC_ADDR_PDIR)
            begin
                port_dir <= wdata_in;
            end
            if (wr_in && addr_in == `IRSFC_ADDR_PDATA)
            begin
                port_data <= wdata_in;
            end
            if (wr_data)
            begin
                tx_hold <= wdata_in;
            end
        end
    end

    // read data, one cycle after the strobe
    always @(posedge clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            rdata_out <= 8'h00;
        end
        else if (rd_in)
        begin
            if (addr_in == `IRSFC_ADDR_CTRL1)
                rdata_out <= ctrl1;
            else if (addr_in == `IRSFC_ADDR_CTRL2)
                rdata_out <= ctrl2;
            else if (addr_in == `IRSFC_ADDR_STAT1)
                rdata_out <= {tx_buffer_empty_flag, tc, rx_full_flag, idle_flag, ovr, 1'b0, fe, pe};
            else if (addr_in == `IRSFC_ADDR_DATA)
                rdata_out <= rx_hold;
            else if (addr_in == `IRSFC_ADDR_BAUD)
                rdata_out <= baud;
            else if (addr_in == `IRSFC_ADDR_IRCR)
                rdata_out <= {r8, t8, 5'h00, ir_on};
            else if (addr_in == `IRSFC_ADDR_PDIR)
                rdata_out <= port_dir;
            else
                rdata_out <= {rx_sync[1], txp_sync[1], port_data[5:0]};
        end
        else
        begin
            rdata_out <= 8'h00;
        end
    end

    // baud generator: sixteen ticks per bit
    always @(posedge clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            div_cnt <= 8'h00;
            rt_tick <= 1'b0;
        end
        else if (!unit)
        begin
            div_cnt <= 8'h00;
            rt_tick <= 1'b0;
        end
        else if (div_cnt >= baud)
        begin
            div_cnt <= 8'h00;
            rt_tick <= 1'b1;
        end
        else
        begin
            div_cnt <= div_cnt + 8'h01;
            rt_tick <= 1'b0;
        end
    end

    // transmitter and its flags
    always @(posedge clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            tx_shift <= 11'h7ff;
            tx_left  <= 4'h0;
            tx_rt    <= 4'h0;
            tx_busy  <= 1'b0;
            tx_pend  <= 1'b0;
            pre_pend <= 1'b0;
            tx_buffer_empty_flag     <= 1'b1;
            tc       <= 1'b1;
        end
        else if (!unit)
        begin
            tx_busy  <= 1'b0;
            tx_pend  <= 1'b0;
            pre_pend <= 1'b0;
            tx_buffer_empty_flag     <= 1'b1;
            tc       <= 1'b1;
        end
        else
        begin
            if (wr_in && addr_in == `IRSFC_ADDR_CTRL2 && wdata_in[`IRSFC_C2_TE])
            begin
                pre_pend <= 1'b1;
                tc       <= 1'b0;
            end
            if (tx_load)
            begin
                tx_busy <= 1'b1;
                tx_rt   <= 4'h0;
                tx_left <= frame_bits;
                tc      <= 1'b0;
                if (pre_pend)
                begin
                    tx_shift <= 11'h7ff;
                    pre_pend <= 1'b0;
                end
                else
                begin
                    tx_pend <= 1'b0;
                    tx_buffer_empty_flag    <= 1'b1;
                    if (char9)
                        tx_shift <= {1'b1, par_on ? parity8(tx_hold, 1'b1, odd) : t8, tx_hold, 1'b0};
                    else
                        tx_shift <= {2'b11, par_on ? parity8(tx_hold, 1'b0, odd) : tx_hold[7],
                                     tx_hold[6:0], 1'b0};
                end
            end
            else if (tx_busy && rt_tick)
            begin
                tx_rt <= tx_rt + 4'h1;
                if (tx_rt == `IRSFC_RT_LAST)
                begin
                    tx_shift <= {1'b1, tx_shift[10:1]};
                    tx_left  <= tx_left - 4'h1;
                    if (tx_left == 4'h1)
                    begin
                        tx_busy <= 1'b0;
                        tc      <= !tx_pend && !pre_pend;
                    end
                end
            end
            // data write clears the empty flag, but a load in the same cycle wins
            if (wr_data)
            begin
                tx_pend <= 1'b1;
                tc      <= 1'b0;
                if (!tx_load)
                begin
                    tx_buffer_empty_flag <= 1'b0;
                end
            end
        end
    end

    irsfc_ir_enc u_ir_enc
    (
        .clk_in      (clk_in),
        .reset_n_in  (reset_n_in),
        .ir_on_in    (ir_on),
        .bit_in      (tx_raw),
        .rt_phase_in (tx_rt),
        .enc_out     (ir_tx)
    );

    // pin synchronisers
    always @(posedge clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            rx_sync  <= 2'b11;
            txp_sync <= 2'b11;
        end
        else
        begin
            rx_sync  <= {rx_sync[0], rx_pin_in};
            txp_sync <= {txp_sync[0], tx_pin_in};
        end
    end

    // pin ownership
    always @(posedge clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            tx_pin_out      <= 1'b0;
            tx_pin_oe_n_out <= 1'b1;
            rx_pin_out      <= 1'b0;
            rx_pin_oe_n_out <= 1'b1;
        end
        else if (unit)
        begin
            tx_pin_out      <= ir_on ? ir_tx : tx_raw;
            tx_pin_oe_n_out <= !(te || tx_busy);
            rx_pin_out      <= 1'b0;
            rx_pin_oe_n_out <= 1'b1;
        end
        else
        begin
            tx_pin_out      <= port_data[6];
            tx_pin_oe_n_out <= !port_dir[6];
            rx_pin_out      <= port_data[7];
            rx_pin_oe_n_out <= !port_dir[7];
        end
    end

    // receiver
    always @(posedge clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            rx_state    <= RX_IDLE;
            rx_rt       <= 4'h0;
            rx_bitn     <= 4'h0;
            rx_shift    <= 9'h000;
            rx_mid      <= 1'b1;
            rx_low_seen <= 1'b0;
        end
        else if (!rx_run)
        begin
            rx_state <= RX_IDLE;
        end
        else if (rt_tick)
        begin
            case (rx_state)
                RX_IDLE:
                begin
                    rx_rt       <= 4'h1;
                    rx_bitn     <= 4'h0;
                    rx_low_seen <= 1'b1;
                    rx_mid      <= 1'b0;
                    if (!rx_line)
                    begin
                        rx_state <= RX_BITS;
                    end
                end
                default:
                begin
                    rx_rt <= rx_rt + 4'h1;
                    if (rx_rt == `IRSFC_RT_MID)
                        rx_mid <= rx_line;
                    if (!rx_line)
                        rx_low_seen <= 1'b1;
                    if (rx_rt == `IRSFC_RT_LAST)
                    begin
                        rx_low_seen <= 1'b0;
                        rx_bitn     <= rx_bitn + 4'h1;
                        if (rx_bitn == 4'h0 && rx_bit)
                            rx_state <= RX_IDLE;
                        else if (rx_bitn == frame_bits - 4'h1)
                            rx_state <= RX_IDLE;
                        else if (rx_bitn != 4'h0)
                            rx_shift <= {rx_bit, rx_shift[8:1]};
                    end
                end
            endcase
        end
    end

    // receive flags and idle detection
    always @(posedge clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            rx_full_flag       <= 1'b0;
            idle_flag  <= 1'b0;
            ovr        <= 1'b0;
            fe         <= 1'b0;
            pe         <= 1'b0;
            rx_hold    <= 8'h00;
            r8         <= 1'b0;
            ones_cnt   <= 4'h0;
            idle_rt    <= 4'h0;
            idle_armed <= 1'b0;
        end
        else
        begin
            if (rd_data)
            begin
                rx_full_flag      <= 1'b0;
                idle_flag <= 1'b0;
                ovr       <= 1'b0;
                fe        <= 1'b0;
                pe        <= 1'b0;
            end
            if (!rx_run)
            begin
                ones_cnt <= 4'h0;
                idle_rt  <= 4'h0;
            end
            else if (rx_done)
            begin
                idle_armed <= 1'b1;
                // count origin after stop or start
                ones_cnt   <= ctrl1[`IRSFC_C1_IDLE_ORG] ? 4'h0 : (rx_bit ? ones_cnt + 4'h1 : 4'h0);
                idle_rt    <= 4'h0;
                if (!standby_bit || (ctrl1[`IRSFC_C1_WAKE] && rx_top))
                begin
                    if (rx_full_flag && !rd_data)
                    begin
                        ovr <= 1'b1;
                    end
                    else
                    begin
                        rx_full_flag    <= 1'b1;
                        rx_hold <= rx_char;
                        r8      <= rx_shift[8];
                        fe      <= !rx_bit;
                        pe      <= par_on && rx_pbad;
                    end
                end
            end
            else if (rx_state == RX_BITS)
            begin
                if (rt_tick && rx_rt == `IRSFC_RT_LAST)
                begin
                    if (rx_bitn == 4'h0 || !rx_bit)
                        ones_cnt <= 4'h0;
                    else if (!ctrl1[`IRSFC_C1_IDLE_ORG])
                        ones_cnt <= ones_cnt + 4'h1;
                end
            end
            else if (idle_hit)
            begin
                idle_armed <= 1'b0;
                if (!(standby_bit && !ctrl1[`IRSFC_C1_WAKE]))
                    idle_flag <= 1'b1;
            end
            else if (rt_tick && rx_line)
            begin
                idle_rt <= idle_rt + 4'h1;
                if (idle_rt == `IRSFC_RT_LAST && ones_cnt != 4'hf)
                    ones_cnt <= ones_cnt + 4'h1;
            end
            else if (rt_tick)
            begin
                idle_rt <= 4'h0;
            end
        end
    end
endmodule
`default_nettype wire

// ===== irsfc_checker.sv
// assertion checker of the serial frame block, bound to its top
`timescale 1ns/1ns
`default_nettype none
`include "irsfc_defines.vh"
module irsfc_checker
(
    input wire logic       clk_in,
    input wire logic       reset_n_in,
    input wire logic [2:0] addr_in,
    input wire logic [7:0] wdata_in,
    input wire logic       wr_in,
    input wire logic       rd_in,
    input wire logic [7:0] rdata_out,
    input wire logic       tx_pin_out,
    input wire logic       tx_pin_oe_n_out,
    input wire logic       rx_pin_oe_n_out
);
    logic [7:0] c1;
    logic [7:0] pdir;
    logic       te;
    logic       ir;
    logic       c1w;
    logic [2:0] lowc;
    wire        unit = c1[`IRSFC_C1_UNIT];
    wire        rc1 = rd_in && addr_in == `IRSFC_ADDR_CTRL1;
    default clocking @(posedge clk_in); endclocking
    default disable iff (!reset_n_in);
    // shadow of control writes, run of driven lows
    always_ff @(posedge clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            c1 <= 8'h00;
            pdir <= 8'h00;
            te <= 1'b0;
            ir <= 1'b0;
            c1w <= 1'b0;
            lowc <= 3'h0;
        end
        else
        begin
            if (wr_in && addr_in == `IRSFC_ADDR_CTRL1)
            begin
                c1 <= wdata_in;
                c1w <= 1'b1;
            end
            if (wr_in && addr_in == `IRSFC_ADDR_CTRL2 && unit)
                te <= wdata_in[`IRSFC_C2_TE];
            if (wr_in && addr_in == `IRSFC_ADDR_IRCR)
                ir <= wdata_in[`IRSFC_IR_EN];
            if (wr_in && addr_in == `IRSFC_ADDR_PDIR)
                pdir <= wdata_in;
            lowc <= (tx_pin_oe_n_out || tx_pin_out) ? 3'h0 : lowc + {2'h0, lowc != 3'h7};
        end
    end
    property p_port_off;
        !unit && !$past(unit) && $stable(pdir) |-> tx_pin_oe_n_out == !pdir[6] && rx_pin_oe_n_out == !pdir[7];
    endproperty
    a_port_off: assert property (p_port_off) else $error("pins not under port control");
    property p_rx_in;
        unit && $past(unit) |-> rx_pin_oe_n_out;
    endproperty
    a_rx_in: assert property (p_rx_in) else $error("receive pin driven");
    property p_tx_on;
        unit && te && $past(unit && te, 2) |-> !tx_pin_oe_n_out;
    endproperty
    a_tx_on: assert property (p_tx_on) else $error("transmit pin not driven");
    property p_tx_rel;
        unit && $fell(te) |-> ##[1:400] tx_pin_oe_n_out;
    endproperty
    a_tx_rel: assert property (p_tx_rel) else $error("transmit pin never released");
    property p_ir;
        unit && ir |-> lowc <= 3'h3;
    endproperty
    a_ir: assert property (p_ir) else $error("infrared low pulse too long");
    property p_stat_off;
        rd_in && addr_in == `IRSFC_ADDR_STAT1 && !unit && !$past(unit) |=> rdata_out[7:6] == 2'b11;
    endproperty
    a_stat_off: assert property (p_stat_off) else $error("empty and done not set");
    property p_c1_rst;
        rc1 && !c1w |=> rdata_out == `IRSFC_RST_CTRL1;
    endproperty
    a_c1_rst: assert property (p_c1_rst) else $error("control one not cleared");
    property p_c1_back;
        rc1 |=> rdata_out == (c1 & `IRSFC_C1_MASK);
    endproperty
    a_c1_back: assert property (p_c1_back) else $error("control one readback");
endmodule
bind irsfc_top irsfc_checker chk_i (.clk_in, .reset_n_in, .addr_in, .wdata_in, .wr_in, .rd_in, .rdata_out,
    .tx_pin_out, .tx_pin_oe_n_out, .rx_pin_oe_n_out);
`default_nettype wire

// ===== irsfc_remote.sv
// remote serial party: sends frames on the receive line, captures the transmit line
`timescale 1ns/1ns
`default_nettype none
module irsfc_remote
(
    input  wire logic clk_in,
    input  wire logic tx_line_in,
    output var logic  rx_line_out
);
    initial rx_line_out = 1'b1;
    task automatic send(input logic [7:0] v);
        logic [9:0] f;
        f = {1'b1, v, 1'b0};
        for (int i = 0; i < 10; i++)
        begin
            rx_line_out <= f[i];
            repeat (16) @(posedge clk_in);
        end
    endtask
    // a bit is zero if any low is seen in it
    task automatic cap(input int n, output logic [9:0] w);
        int   t;
        logic b;
        w = 10'h000;
        t = 0;
        while (tx_line_in !== 1'b0 && t < 3000)
        begin
            @(posedge clk_in);
            t++;
        end
        repeat (15) @(posedge clk_in);
        for (int i = 0; i <= n; i++)
        begin
            b = 1'b1;
            repeat (16)
            begin
                @(posedge clk_in);
                b = b & tx_line_in;
            end
            w[i] = b;
        end
    endtask
endmodule
`default_nettype wire

// ===== ir_serial_frame_config_bench.sv
// self-checking bench of the serial frame block
`timescale 1ns/1ns
`default_nettype none
`include "irsfc_defines.vh"
module ir_serial_frame_config_bench;
    localparam logic [2:0] C1 = `IRSFC_ADDR_CTRL1, C2 = `IRSFC_ADDR_CTRL2, ST = `IRSFC_ADDR_STAT1;
    localparam logic [2:0] DT = `IRSFC_ADDR_DATA, IR = `IRSFC_ADDR_IRCR, PD = `IRSFC_ADDR_PDIR;
    logic       clk_in;
    logic       reset_n_in;
    logic [2:0] addr_in;
    logic [7:0] wdata_in;
    logic       wr_in;
    logic       rd_in;
    wire  [7:0] rdata_out;
    wire        tx_pin_out;
    wire        tx_pin_oe_n_out;
    wire        rx_pin_out;
    wire        rx_pin_oe_n_out;
    wire        rem_rx;
    int         err_total = 0;
    int         tests_run = 0;
    // open-drain lines with pull-ups
    wire        tx_line = tx_pin_oe_n_out | tx_pin_out;
    wire        rx_line = rem_rx & (rx_pin_oe_n_out | rx_pin_out);
    irsfc_top dut (.clk_in, .reset_n_in, .addr_in, .wdata_in, .wr_in, .rd_in, .rdata_out, .tx_pin_out,
        .tx_pin_oe_n_out, .tx_pin_in(tx_line), .rx_pin_out, .rx_pin_oe_n_out, .rx_pin_in(rx_line));
    irsfc_remote rem (.clk_in, .tx_line_in(tx_line), .rx_line_out(rem_rx));
    initial
    begin
        clk_in = 1'b0;
        forever #4 clk_in = ~clk_in;
    end
    task automatic print_verdict;
        if (err_total == 0 && tests_run > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task automatic chk(input logic [9:0] g, input logic [9:0] e);
        tests_run++;
        if (g !== e)
        begin
            err_total++;
            $display("wrong value at %0t: got %h want %h", $time, g, e);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_in);
        #1;
    endtask
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk_in);
        addr_in <= a;
        wdata_in <= d;
        wr_in <= 1'b1;
        @(posedge clk_in);
        wr_in <= 1'b0;
    endtask
    task automatic rc(input logic [2:0] a, input logic [7:0] e, input logic [7:0] m);
        @(posedge clk_in);
        addr_in <= a;
        rd_in <= 1'b1;
        @(posedge clk_in);
        rd_in <= 1'b0;
        #1;
        chk({2'h0, rdata_out & m}, {2'h0, e});
    endtask
    task automatic xmit(input int n, input logic [7:0] d, input logic [9:0] e);
        logic [9:0] w;
        fork
            rem.cap(n, w);
            wr(DT, d);
        join
        chk(w, e);
    endtask
    initial
    begin
        #400000;
        err_total++;
        print_verdict;
    end
    initial
    begin
        reset_n_in <= 1'b0;
        addr_in <= 3'h0;
        wdata_in <= 8'h00;
        wr_in <= 1'b0;
        rd_in <= 1'b0;
        repeat (2) @(posedge clk_in);
        reset_n_in <= 1'b1;
        rc(C1, 8'h00, 8'hff);
        rc(ST, 8'hc0, 8'hff);
        wr(PD, 8'hc0);
        cyc(2);
        chk({9'h0, tx_pin_oe_n_out}, 10'h000);
        wr(C1, 8'h40);
        wr(C2, 8'h0c);
        cyc(2);
        chk({9'h0, rx_pin_oe_n_out}, 10'h001);
        xmit(8, 8'ha5, 10'h1a5);
        for (int i = 0; i < 2; i++)
        begin
            wr(C1, {7'h21, i[0]});
            xmit(8, 8'h01, (i != 0) ? 10'h101 : 10'h181);
        end
        wr(C1, 8'h50);
        wr(IR, 8'h40);
        xmit(9, 8'h00, 10'h300);
        wr(C1, 8'h40);
        wr(IR, 8'h41);
        xmit(8, 8'h96, 10'h196);
        rem.send(8'h5a);
        cyc(200);
        rc(ST, 8'h30, 8'h30);
        rc(DT, 8'h5a, 8'hff);
        wr(IR, 8'h00);
        wr(C1, 8'h42);
        rem.send(8'h01);
        cyc(20);
        rc(ST, 8'h21, 8'h21);
        rc(DT, 8'h01, 8'hff);
        wr(C2, 8'h08);
        rem.send(8'h11);
        cyc(200);
        rc(ST, 8'h00, 8'h20);
        wr(C1, 8'h48);
        wr(C2, 8'h0e);
        rem.send(8'h01);
        cyc(20);
        rc(ST, 8'h00, 8'h20);
        rc(C2, 8'h0e, 8'hff);
        rem.send(8'h81);
        cyc(20);
        rc(ST, 8'h20, 8'h20);
        rc(C2, 8'h0c, 8'hff);
        rc(DT, 8'h81, 8'hff);
        wr(C1, 8'h40);
        wr(C2, 8'h0e);
        rem.send(8'h00);
        cyc(250);
        rc(C2, 8'h0c, 8'hff);
        wr(C1, 8'hc0);
        wr(IR, 8'h01);
        fork
            rem.send(8'hf0);
            wr(DT, 8'h3c);
        join
        cyc(200);
        rc(DT, 8'h3c, 8'hff);
        wr(IR, 8'h00);
        wr(C1, 8'h40);
        wr(DT, 8'h0f);
        cyc(8);
        wr(C2, 8'h04);
        cyc(2);
        chk({9'h0, tx_pin_oe_n_out}, 10'h000);
        cyc(300);
        chk({9'h0, tx_pin_oe_n_out}, 10'h001);
        wr(C2, 8'hcc);
        wr(DT, 8'hff);
        cyc(8);
        wr(C1, 8'h00);
        rc(ST, 8'hc0, 8'hc0);
        rc(C2, 8'h00, 8'hc0);
        cyc(2);
        chk({8'h0, rx_pin_oe_n_out, tx_pin_oe_n_out}, 10'h000);
        wr(`IRSFC_ADDR_PDATA, 8'h80);
        cyc(2);
        chk({8'h0, rx_pin_out, tx_pin_out}, 10'h002);
        rc(`IRSFC_ADDR_PDATA, 8'h80, 8'hff);
        wr(PD, 8'h00);
        cyc(2);
        chk({8'h0, rx_pin_oe_n_out, tx_pin_oe_n_out}, 10'h003);
        print_verdict;
    end
endmodule
`default_nettype wire
